// >>> design/asc_params.svh
// Function
// RULE1: sample codes 0x6..0xA auto-shift sum by 2..6; with extra_shift 0x4 gives 12 bits.
// RULE2: n extra bits: accumulate 4^n samples, shift n total (auto plus extra_shift).
// RULE3: software picks 13/14/15/16 bits as 0x2/0x1, 0x4/0x2, 0x6/0x1, 0x8/0x0.
// RULE4: one start converts every positive input whose scan_input_mask bit is set.
// RULE5: scan converts selected inputs lowest multiplexer index first.
// RULE6: differential mode uses neg_input_sel for every conversion of the scan.
// RULE7: scan_active sets when a scan starts, clears when it completes.
// RULE8: each finished conversion records scan_last_input, stores result, sets conv_done_flag.
// RULE9: next listed input starts automatically without another start request.
// RULE10: empty scan_input_mask means one conversion on pos_input_sel.
// RULE11: any enabled event acts; flush beats start when both arrive together.
// RULE12: sleep settings matter only when enabled; disabled stays disabled.
// RULE13: enabled, both clear: run in all sleep modes except standby.
// RULE14: enabled, on-request only: run on request in all sleep modes except standby.
// RULE15: keep_running_sleep set: run in standby too, continuous or on request.
// RULE16: on request: power core down after conversion, wait start-up before next.
// RULE17: scan_status holds scan_active at bit 7, scan_last_input at bits 4:0.
// RULE18: accumulator at least 22 bits so 1024 12-bit samples never overflow.
// RULE19: start during an active scan neither restarts nor corrupts it.
`ifndef ASC_PARAMS_SVH
`define ASC_PARAMS_SVH

// ==========================================================
// register byte offsets
`define ASC_OFS_MAIN_CONTROL 8'h00
`define ASC_OFS_AVERAGING_CFG 8'h04
`define ASC_OFS_INPUT_SEL 8'h08
`define ASC_OFS_SCAN_MASK 8'h0C
`define ASC_OFS_SCAN_STATUS 8'h10
`define ASC_OFS_TRIGGER 8'h14
`define ASC_OFS_RESULT 8'h18
`define ASC_OFS_IRQ_FLAGS 8'h1C
`define ASC_OFS_IRQ_MASK 8'h20
`define ASC_OFS_EVENT_CTRL 8'h24

// ==========================================================
// field positions
`define ASC_MC_ENABLE 0
`define ASC_MC_KEEP_RUN 1
`define ASC_MC_ON_REQ 2
`define ASC_MC_DIFF 3
`define ASC_ST_ACTIVE 7
`define ASC_TRG_FLUSH 0
`define ASC_TRG_START 1
`define ASC_EV_START 0
`define ASC_EV_FLUSH 1
`define ASC_IRQ_CONV_DONE 0
`define ASC_IRQ_SCAN_DONE 1

// ==========================================================
// codes, reset values and timing
`define ASC_CODE_MAX 4'hA
`define ASC_CODE_NOSHIFT 4'h4
`define ASC_RST_ZERO 32'h0000_0000
`define ASC_STARTUP_NS 2000
`define ASC_CLK_NS 100

`endif

// >>> design/asc_pkg.sv
package asc_pkg;

  // ==========================================================
  // scan sequencer states
  typedef enum logic [1:0] {ASC_IDLE, ASC_WAKE, ASC_CONV} asc_state_t;

  // ==========================================================
  // analog core request and answer
  typedef struct packed {
    logic power_on;
    logic conv_req;
    logic diff;
    logic [4:0] pos;
    logic [4:0] neg;
  } asc_core_req_t;

  typedef struct packed {
    logic sample_valid;
    logic [11:0] sample;
  } asc_core_rsp_t;

  // ==========================================================
  // main control fields
  typedef struct packed {
    logic diff;
    logic on_req;
    logic keep_run;
    logic enable;
  } asc_ctrl_t;

endpackage

// >>> design/asc_ctrl.sv
`timescale 1ns/10ps
`include "asc_params.svh"

module asc_ctrl
  import asc_pkg::*;
#(
  parameter int ACC_W = 22,
  parameter int RES_W = 16
)
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic evt_start,
  input wire logic evt_flush,
  input wire logic sleep_active,
  input wire logic sleep_standby,
  input wire asc_core_rsp_t core_rsp,
  output asc_core_req_t core_req,
  output logic irq
);

  // ==========================================================
  // elaboration checks and derived counts
  localparam int STARTUP_CYC = (`ASC_STARTUP_NS + `ASC_CLK_NS - 1) / `ASC_CLK_NS;
  localparam int STUP_W = $clog2(STARTUP_CYC + 1);

  initial
  begin
    if (ACC_W < 22)
      $error("asc_ctrl: accumulator narrower than 22 bits overflows"); // [RULE18]
    if (RES_W < 16 || RES_W > 32)
      $error("asc_ctrl: result width must be 16 to 32");
  end

  // ==========================================================
  // helper functions
  // byte-lane merge honouring the write strobes
  function automatic logic [31:0] wmerge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    return r;
  endfunction

  // lowest set bit of a mask; scans run upward from input 0
  function automatic logic [4:0] lowest(input logic [31:0] m);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 31; i >= 0; i--)
      if (m[i])
        r = 5'(i);
    return r;
  endfunction

  // ==========================================================
  // register state
  asc_ctrl_t ctrl_ff;
  logic [6:0] avg_ff;
  logic [4:0] pos_sel_ff, neg_sel_ff, last_in_ff;
  logic [31:0] mask_ff;
  logic [1:0] ev_en_ff, irq_mask_ff, irq_flag_ff;
  logic [RES_W-1:0] result_ff;
  logic scan_active_ff;
  // sequencer state
  asc_state_t state_ff;
  logic pend_ff, diff_ff, pwr_ff, warm_ff;
  logic [31:0] rem_ff;
  logic [4:0] ch_ff, neg_ff;
  logic [ACC_W-1:0] acc_ff;
  logic [10:0] smp_cnt_ff;
  logic [STUP_W-1:0] stup_cnt_ff;
  // axi handshake state
  logic aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff, rdata_ff;
  logic [3:0] w_strb_ff;
  logic [1:0] bresp_ff, rresp_ff;

  // ==========================================================
  // axi4-lite write path: address and data taken in either order
  assign s_axi_awready = !aw_hold_ff;
  assign s_axi_wready = !w_hold_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_fire = aw_hold_ff && w_hold_ff && !bvalid_ff;

  wire wr_mc = wr_fire && aw_addr_ff == `ASC_OFS_MAIN_CONTROL;
  wire wr_avg = wr_fire && aw_addr_ff == `ASC_OFS_AVERAGING_CFG;
  wire wr_inp = wr_fire && aw_addr_ff == `ASC_OFS_INPUT_SEL;
  wire wr_msk = wr_fire && aw_addr_ff == `ASC_OFS_SCAN_MASK;
  wire wr_trg = wr_fire && aw_addr_ff == `ASC_OFS_TRIGGER;
  wire wr_ifl = wr_fire && aw_addr_ff == `ASC_OFS_IRQ_FLAGS;
  wire wr_imk = wr_fire && aw_addr_ff == `ASC_OFS_IRQ_MASK;
  wire wr_evc = wr_fire && aw_addr_ff == `ASC_OFS_EVENT_CTRL;
  // status and result are read only, so a write there is an error too
  wire wr_ok = wr_mc || wr_avg || wr_inp || wr_msk || wr_trg || wr_ifl || wr_imk || wr_evc;
  wire [31:0] wr_val = wmerge(`ASC_RST_ZERO, w_data_ff, w_strb_ff);

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      {aw_hold_ff, w_hold_ff, bvalid_ff, bresp_ff} <= '0;
      {aw_addr_ff, w_data_ff, w_strb_ff} <= '0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (w_take)
      begin
        w_hold_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_ok ? 2'h0 : 2'h2;  // slverr on unmapped
      end
      else if (s_axi_bready)
        bvalid_ff <= 1'b0;
    end
  end

  // ==========================================================
  // axi4-lite read path: one read at a time, answer one cycle later
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
  wire [31:0] st_word = {24'h000000, scan_active_ff, 2'b00, last_in_ff}; // [RULE17]
  wire rd_hit = ra <= `ASC_OFS_EVENT_CTRL; // the map is one run of words from zero
  wire [31:0] rd_mux =
    ra == `ASC_OFS_MAIN_CONTROL ? {28'h0000000, ctrl_ff} :
    ra == `ASC_OFS_AVERAGING_CFG ? {25'h0000000, avg_ff} :
    ra == `ASC_OFS_INPUT_SEL ? {19'h00000, neg_sel_ff, 3'h0, pos_sel_ff} :
    ra == `ASC_OFS_SCAN_MASK ? mask_ff :
    ra == `ASC_OFS_SCAN_STATUS ? st_word :
    ra == `ASC_OFS_RESULT ? 32'(result_ff) :
    ra == `ASC_OFS_IRQ_FLAGS ? {30'h00000000, irq_flag_ff} :
    ra == `ASC_OFS_IRQ_MASK ? {30'h00000000, irq_mask_ff} :
    ra == `ASC_OFS_EVENT_CTRL ? {30'h00000000, ev_en_ff} : 32'h0000_0000;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      {rvalid_ff, rdata_ff, rresp_ff} <= '0;
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_ff <= rd_hit ? 2'h0 : 2'h2;
    end
    else if (s_axi_rready)
      rvalid_ff <= 1'b0;
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ctrl_ff <= asc_ctrl_t'(4'h0);
      avg_ff <= 7'h00;
      pos_sel_ff <= 5'h00;
      neg_sel_ff <= 5'h00;
      mask_ff <= `ASC_RST_ZERO;
      ev_en_ff <= 2'h0;
      irq_mask_ff <= 2'h0;
    end
    else
    begin
      if (wr_mc && w_strb_ff[0])
        ctrl_ff <= asc_ctrl_t'(w_data_ff[3:0]);
      if (wr_avg && w_strb_ff[0])
        avg_ff <= w_data_ff[6:0];
      if (wr_inp && w_strb_ff[0])
        pos_sel_ff <= w_data_ff[4:0];
      if (wr_inp && w_strb_ff[1])
        neg_sel_ff <= w_data_ff[12:8];
      if (wr_msk)
        mask_ff <= wmerge(mask_ff, w_data_ff, w_strb_ff);
      if (wr_evc && w_strb_ff[0])
        ev_en_ff <= w_data_ff[1:0];
      if (wr_imk && w_strb_ff[0])
        irq_mask_ff <= w_data_ff[1:0];
    end
  end

  // ==========================================================
  // start and flush requests from software and events
  wire sw_start = wr_trg && wr_val[`ASC_TRG_START];
  wire sw_flush = wr_trg && wr_val[`ASC_TRG_FLUSH];
  wire any_flush = sw_flush || (evt_flush && ev_en_ff[`ASC_EV_FLUSH]); // [RULE11]
  wire any_start = sw_start || (evt_start && ev_en_ff[`ASC_EV_START]); // [RULE11]
  wire start_eff = any_start && !any_flush; // flush wins a tie [RULE11]

  // ==========================================================
  // sleep policy: settings only matter while enabled
  wire en = ctrl_ff.enable; // [RULE12]
  // standby stops the block unless keep_running_sleep is set
  wire run_ok = en && !(sleep_active && sleep_standby && !ctrl_ff.keep_run); // [RULE13] [RULE15]
  // on-request mode powers the core only while work is queued or running
  wire nxt_pwr = run_ok && (!ctrl_ff.on_req || pend_ff || state_ff != ASC_IDLE); // [RULE14] [RULE16]

  // ==========================================================
  // averaging arithmetic
  wire [3:0] code = avg_ff[3:0] > `ASC_CODE_MAX ? 4'h0 : avg_ff[3:0];
  wire [2:0] extra_shift = avg_ff[6:4];
  // auto shift only beyond 16 samples keeps the sum inside 16 bits [RULE1]
  wire [3:0] auto_shift = code > `ASC_CODE_NOSHIFT ? code - `ASC_CODE_NOSHIFT : 4'h0;
  wire [4:0] tot_shift = 5'(auto_shift) + 5'(extra_shift); // [RULE2]
  wire [10:0] n_last = 11'((12'h001 << code) - 12'h001);
  wire [ACC_W-1:0] acc_sum = acc_ff + ACC_W'(core_rsp.sample); // [RULE18]
  wire [ACC_W-1:0] acc_shr = acc_sum >> tot_shift; // [RULE1] [RULE2]
  wire conv_on = state_ff == ASC_CONV && run_ok && warm_ff;
  wire smp_take = conv_on && core_rsp.sample_valid;
  wire conv_end = smp_take && smp_cnt_ff == n_last;
  wire [31:0] rem_after = rem_ff & ~(32'h0000_0001 << ch_ff);
  wire scan_more = rem_after != 32'h0000_0000;
  wire take_job = state_ff == ASC_IDLE && pend_ff && run_ok && !any_flush;

  // ==========================================================
  // analog power and start-up delay
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      {pwr_ff, warm_ff, stup_cnt_ff} <= '0;
    else
    begin
      pwr_ff <= nxt_pwr;
      if (!nxt_pwr)
      begin
        warm_ff <= 1'b0;
        stup_cnt_ff <= '0;
      end
      else if (pwr_ff && !warm_ff)
      begin
        // conversions wait the full start-up after every power-on [RULE16]
        stup_cnt_ff <= stup_cnt_ff + 1'b1;
        warm_ff <= stup_cnt_ff == STUP_W'(STARTUP_CYC - 1);
      end
    end
  end

  // ==========================================================
  // scan sequencer
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state_ff <= ASC_IDLE;
      pend_ff <= 1'b0;
      rem_ff <= `ASC_RST_ZERO;
      {ch_ff, neg_ff, diff_ff} <= '0;
      acc_ff <= '0;
      smp_cnt_ff <= 11'h000;
      scan_active_ff <= 1'b0;
    end
    else if (!en)
    begin
      state_ff <= ASC_IDLE;
      pend_ff <= 1'b0;
      scan_active_ff <= 1'b0;
    end
    else if (any_flush)
    begin
      // abort and lose work in flight; an interrupted job stays pending and restarts from its first input
      pend_ff <= pend_ff || state_ff != ASC_IDLE;
      state_ff <= ASC_IDLE;
      scan_active_ff <= 1'b0;
      acc_ff <= '0;
      smp_cnt_ff <= 11'h000;
    end
    else
    begin
      case (state_ff)
        ASC_IDLE:
        begin
          if (start_eff)
            pend_ff <= 1'b1;
          if (take_job)
          begin
            pend_ff <= 1'b0;
            rem_ff <= mask_ff; // [RULE4]
            ch_ff <= mask_ff != 32'h0 ? lowest(mask_ff) : pos_sel_ff; // [RULE5] [RULE10]
            scan_active_ff <= mask_ff != 32'h0; // [RULE7]
            neg_ff <= neg_sel_ff; // held for the whole scan [RULE6]
            diff_ff <= ctrl_ff.diff; // [RULE6]
            acc_ff <= '0;
            smp_cnt_ff <= 11'h000;
            state_ff <= ASC_WAKE;
          end
        end
        ASC_WAKE:
          // starts here are dropped, the running scan is untouched [RULE19]
          if (warm_ff)
            state_ff <= ASC_CONV;
        ASC_CONV:
        begin
          if (smp_take)
          begin
            acc_ff <= conv_end ? '0 : acc_sum;
            smp_cnt_ff <= conv_end ? 11'h000 : smp_cnt_ff + 11'h001;
          end
          if (conv_end)
          begin
            rem_ff <= rem_after;
            if (scan_more)
              ch_ff <= lowest(rem_after); // no new start needed [RULE9] [RULE5]
            else
            begin
              state_ff <= ASC_IDLE;
              scan_active_ff <= 1'b0; // [RULE7]
            end
          end
        end
        default:
          state_ff <= ASC_IDLE;
      endcase
    end
  end

  // ==========================================================
  // result, last input and interrupt flags
  wire [1:0] ev_set = {conv_end && !scan_more && !any_flush && en, conv_end && !any_flush && en};
  wire [1:0] ev_clr = wr_ifl && w_strb_ff[0] ? w_data_ff[1:0] : 2'h0;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      result_ff <= '0;
      last_in_ff <= 5'h00;
      irq_flag_ff <= 2'h0;
    end
    else
    begin
      if (ev_set[`ASC_IRQ_CONV_DONE])
      begin
        result_ff <= RES_W'(acc_shr); // [RULE8]
        last_in_ff <= ch_ff; // [RULE8] [RULE17]
      end
      // a set in the same cycle as a write-one-clear wins
      irq_flag_ff <= (irq_flag_ff & ~ev_clr) | ev_set; // [RULE8]
    end
  end

  assign irq = |(irq_flag_ff & irq_mask_ff);

  // ==========================================================
  // analog core request
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      core_req <= '0;
    else
    begin
      core_req.power_on <= nxt_pwr;
      core_req.pos <= ch_ff;
      core_req.neg <= neg_ff; // [RULE6]
      core_req.diff <= diff_ff;
      core_req.conv_req <= conv_on && !conv_end && !any_flush;
    end
  end

endmodule // asc_ctrl

// >>> test/asc_ctrl_props.sv
`timescale 1ns/10ps
// ==========================================================
// port-level checks for the converter control
module asc_ctrl_props
  import asc_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire asc_core_req_t core_req
);
  logic [5:0] pwr_cnt_ff;

  // powered cycles, saturating so a long run never wraps back to zero
  always_ff @(posedge mclk)
  begin
    if (sys_rst || !core_req.power_on)
      pwr_cnt_ff <= 6'h00;
    else if (pwr_cnt_ff != 6'h3F)
      pwr_cnt_ff <= pwr_cnt_ff + 6'h01;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // analog core sequencing
  property p_warm_up;
    core_req.conv_req |-> core_req.power_on && (pwr_cnt_ff >= 6'h14);
  endproperty
  a_warm_up: assert property (p_warm_up)
    else $error("conversion before warm-up");

  // the single idle cycle between two inputs of a scan marks a step
  property p_ascend;
    core_req.conv_req && !$past(core_req.conv_req) && $past(core_req.conv_req, 2)
      |-> core_req.pos > $past(core_req.pos, 2);
  endproperty
  a_ascend: assert property (p_ascend)
    else $error("scan stepped down");

  property p_neg_hold;
    core_req.conv_req && $past(core_req.conv_req)
      |-> $stable(core_req.neg) && $stable(core_req.diff);
  endproperty
  a_neg_hold: assert property (p_neg_hold)
    else $error("negative input moved in scan");

  // ==========================================================
  // register bus handshakes
  property p_write_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write response late");

  property p_bresp_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bresp_hold: assert property (p_bresp_hold)
    else $error("write response dropped");

  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read data late");

  property p_rdata_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved early");

  property p_read_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_read_block: assert property (p_read_block)
    else $error("read taken while data waits");
endmodule // asc_ctrl_props

// >>> test/asc_core_model.sv
`timescale 1ns/10ps
// ==========================================================
// behavioural analog core: one sample per cycle, or one in twelve when slow
module asc_core_model
  import asc_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic slow,
  input wire asc_core_req_t core_req,
  output asc_core_rsp_t core_rsp
);
  logic [3:0] gap_ff;
  logic [11:0] last_ff;
  logic [11:0] level;
  logic live;
  logic fire;

  // input 31 gives full scale so the widest sum is exercised
  assign level = (core_req.pos == 5'h1F) ? 12'hFFF : 12'h100 + {7'h00, core_req.pos};
  assign live = core_req.power_on && core_req.conv_req;
  assign fire = live && (slow ? (gap_ff == 4'hB) : 1'b1);

  always_ff @(posedge mclk)
  begin
    if (sys_rst || !live || fire)
      gap_ff <= 4'h0;
    else
      gap_ff <= gap_ff + 4'h1;
    if (sys_rst)
      last_ff <= 12'h000;
    else if (fire)
      last_ff <= level;
  end

  // between samples the data lines show the inverse, never a stale copy
  assign core_rsp.sample_valid = fire;
  assign core_rsp.sample = fire ? level : ~last_ff;
endmodule // asc_core_model

// >>> test/tb_asc_ctrl.sv
`timescale 1ns/10ps
`include "asc_params.svh"
`define CHK(nm, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("[FAIL] %s expected %h seen %h", nm, (e), (g)); \
    end \
  end

module tb_asc_ctrl import asc_pkg::*;;
  logic mclk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic evt_start, evt_flush, sleep_active, sleep_standby, slow, irq;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
  asc_core_req_t core_req;
  asc_core_rsp_t core_rsp;
  int fail_count = 0;
  int checked = 0;
  logic [10:0] seen_q[$];

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  asc_ctrl i_asc_ctrl (.mclk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .evt_start, .evt_flush, .sleep_active, .sleep_standby,
    .core_rsp, .core_req, .irq);

  asc_core_model i_asc_core_model (.mclk, .sys_rst, .slow, .core_req, .core_rsp);

  // log every accepted sample as {diff, pos, neg}
  always @(posedge mclk)
    if (!sys_rst && core_rsp.sample_valid && core_req.conv_req)
      seen_q.push_back({core_req.diff, core_req.pos, core_req.neg});

  // ==========================================================
  // bus tasks; ready is raised only after valid so the hold checks fire
  // bus waits have no limit of their own: the watchdog ends a hang; wait_irq gives up after 3000 cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done, w_done;
    {aw_done, w_done} = 2'b00;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
    while (!(aw_done && w_done))
    begin
      @(posedge mclk);
      aw_done = aw_done || s_axi_awready;
      w_done = w_done || s_axi_wready;
      s_axi_awvalid <= !aw_done;
      s_axi_wvalid <= !w_done;
    end
    while (s_axi_bvalid !== 1'b1)
      @(posedge mclk);
    s_axi_bready <= 1'b1;
    @(posedge mclk);
    rd_r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
      @(posedge mclk);
    while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1)
      @(posedge mclk);
    s_axi_rready <= 1'b1;
    @(posedge mclk);
    {rd_d, rd_r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    rd(a);
    `CHK(nm, e, rd_d)
  endtask

  task automatic wait_irq();
    for (int n = 0; n < 3000 && irq !== 1'b1; n++)
      @(posedge mclk);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_regs();
    chk_rd(`ASC_OFS_MAIN_CONTROL, `ASC_RST_ZERO, "main_control reset");
    chk_rd(`ASC_OFS_SCAN_STATUS, `ASC_RST_ZERO, "scan_status reset");
    chk_rd(`ASC_OFS_IRQ_FLAGS, `ASC_RST_ZERO, "irq_flags reset");
    chk_rd(8'h30, `ASC_RST_ZERO, "unmapped read data");
    `CHK("unmapped rresp", 2'h2, rd_r)
    wr(`ASC_OFS_RESULT, 32'h0000_FFFF);
    `CHK("result write bresp", 2'h2, rd_r)
  endtask

  task automatic t_avg();
    logic [6:0] cfg [9];
    int c, sh;
    cfg = '{7'h46, 7'h47, 7'h48, 7'h49, 7'h4A, 7'h12, 7'h24, 7'h16, 7'h08};
    sleep_active <= 1'b1;
    wr(`ASC_OFS_MAIN_CONTROL, 32'h0000_0001);
    wr(`ASC_OFS_INPUT_SEL, 32'h0000_001F);
    wr(`ASC_OFS_IRQ_MASK, 32'h0000_0001);
    foreach (cfg[i])
    begin
      c = cfg[i][3:0];
      sh = ((c > 4) ? c - 4 : 0) + cfg[i][6:4];
      wr(`ASC_OFS_IRQ_FLAGS, 32'h0000_0003);
      wr(`ASC_OFS_AVERAGING_CFG, {25'h0, cfg[i]});
      wr(`ASC_OFS_TRIGGER, 32'h0000_0002);
      wait_irq();
      `CHK("conv done irq", 1'b1, irq)
      chk_rd(`ASC_OFS_RESULT, (32'hFFF << c) >> sh, "result");
      chk_rd(`ASC_OFS_SCAN_STATUS, 32'h0000_001F, "single status");
    end
    sleep_active <= 1'b0;
  endtask

  task automatic t_scan();
    logic [4:0] order [3];
    order = '{5'h03, 5'h0A, 5'h1F};
    seen_q.delete();
    slow <= 1'b1;
    wr(`ASC_OFS_MAIN_CONTROL, 32'h0000_0009);
    wr(`ASC_OFS_INPUT_SEL, 32'h0000_0500);
    wr(`ASC_OFS_AVERAGING_CFG, 32'h0000_0000);
    wr(`ASC_OFS_SCAN_MASK, 32'h8000_0408);
    wr(`ASC_OFS_IRQ_FLAGS, 32'h0000_0003);
    wr(`ASC_OFS_IRQ_MASK, 32'h0000_0002);
    wr(`ASC_OFS_TRIGGER, 32'h0000_0002);
    rd(`ASC_OFS_SCAN_STATUS);
    `CHK("scan_active during scan", 1'b1, rd_d[7])
    wr(`ASC_OFS_TRIGGER, 32'h0000_0002);
    wait_irq();
    `CHK("scan done irq", 1'b1, irq)
    repeat (40) @(posedge mclk);
    `CHK("scan samples", 3, seen_q.size())
    foreach (order[i])
      `CHK("scan input", {1'b1, order[i], 5'h05}, seen_q[i])
    chk_rd(`ASC_OFS_SCAN_STATUS, 32'h0000_001F, "scan status end");
    chk_rd(`ASC_OFS_RESULT, 32'h0000_0FFF, "scan result");
    wr(`ASC_OFS_IRQ_MASK, 32'h0000_0000);
    `CHK("masked irq", 1'b0, irq)
    wr(`ASC_OFS_IRQ_MASK, 32'h0000_0002);
    `CHK("unmasked irq", 1'b1, irq)
    wr(`ASC_OFS_IRQ_FLAGS, 32'h0000_0002);
    `CHK("cleared irq", 1'b0, irq)
    slow <= 1'b0;
  endtask

  task automatic t_evt();
    wr(`ASC_OFS_SCAN_MASK, 32'h0000_0000);
    wr(`ASC_OFS_INPUT_SEL, 32'h0000_0002);
    wr(`ASC_OFS_EVENT_CTRL, 32'h0000_0003);
    wr(`ASC_OFS_IRQ_FLAGS, 32'h0000_0003);
    wr(`ASC_OFS_IRQ_MASK, 32'h0000_0001);
    seen_q.delete();
    evt_start <= 1'b1;
    evt_flush <= 1'b1;
    @(posedge mclk);
    evt_start <= 1'b0;
    evt_flush <= 1'b0;
    repeat (60) @(posedge mclk);
    `CHK("flush beats start", 0, seen_q.size())
    evt_start <= 1'b1;
    @(posedge mclk);
    evt_start <= 1'b0;
    wait_irq();
    `CHK("start event irq", 1'b1, irq)
    chk_rd(`ASC_OFS_RESULT, 32'h0000_0102, "event result");
  endtask

  task automatic t_sleep();
    wr(`ASC_OFS_EVENT_CTRL, 32'h0000_0000);
    wr(`ASC_OFS_MAIN_CONTROL, 32'h0000_0000);
    wr(`ASC_OFS_IRQ_FLAGS, 32'h0000_0003);
    wr(`ASC_OFS_TRIGGER, 32'h0000_0002);
    repeat (60) @(posedge mclk);
    `CHK("disabled irq", 1'b0, irq)
    `CHK("disabled conv_req", 1'b0, core_req.conv_req)
    wr(`ASC_OFS_TRIGGER, 32'h0000_0001);
    sleep_active <= 1'b1;
    sleep_standby <= 1'b1;
    wr(`ASC_OFS_MAIN_CONTROL, 32'h0000_0005);
    wr(`ASC_OFS_TRIGGER, 32'h0000_0002);
    repeat (60) @(posedge mclk);
    `CHK("standby stall irq", 1'b0, irq)
    wr(`ASC_OFS_MAIN_CONTROL, 32'h0000_0007);
    wait_irq();
    `CHK("standby keep-run irq", 1'b1, irq)
    for (int n = 0; n < 10 && core_req.power_on !== 1'b0; n++)
      @(posedge mclk);
    `CHK("on-request power down", 1'b0, core_req.power_on)
    wr(`ASC_OFS_IRQ_FLAGS, 32'h0000_0003);
    wr(`ASC_OFS_TRIGGER, 32'h0000_0002);
    wait_irq();
    `CHK("on-request wake irq", 1'b1, irq)
    sleep_active <= 1'b0;
    sleep_standby <= 1'b0;
  endtask

  task automatic stop_test();
    if (fail_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    {sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h01 << 5;
    {evt_start, evt_flush, sleep_active, sleep_standby, slow} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    t_regs();
    t_avg();
    t_scan();
    t_evt();
    t_sleep();
    stop_test();
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    stop_test();
  end
endmodule // tb_asc_ctrl

bind asc_ctrl asc_ctrl_props i_asc_ctrl_props (.mclk, .sys_rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .core_req);
